// ---- design/vrc_reference_control.v ----
// voltage reference control register and its analog control outputs
//
// Functional notes
// [R1] one 8-bit control register at special-function address d1, resets to zero
// [R2] bits 7 to 5 hold nothing, read as zero, writes ignored
// [R3] bit 2 switches the temperature sensor on when set, off when clear
// [R4] sensor output to converter mux is high impedance while sensor disabled; here temp_mux_oe is registered and drops one sys_ce clock after bit 2 clears
// [R5] bit 1 enables the bias and reference generator
// [R6] bit 0 enables the gain-of-two buffer driving the reference pin
// [R7] buffer output is high impedance and pin undriven while bit 0 clear
// [R8] bit 4 picks first converter reference: pin when zero, first dac when one
// [R9] bit 3 picks second converter reference: pin when zero, supply when one
// [R10] software sets bias and buffer enables for bandgap reference or dac use
// [R11] software sets bias enable whenever either converter runs
// [R12] software may clear buffer or both enables to save power when idle
`timescale 1ns/1ps
`include "vrc_defines.vh"
module vrc_reference_control
(
  sys_clk,
  rst_n,
  sys_ce,
  sfr_addr,
  sfr_wr,
  sfr_rd,
  sfr_wdata,
  sfr_rdata,
  sfr_rd_hit,
  temp_sensor_code,
  temp_mux_code,
  temp_mux_oe,
  ref_pin_o,
  ref_pin_oe,
  temp_sensor_enable,
  bias_generator_enable,
  reference_buffer_enable,
  first_converter_ref_select,
  second_converter_ref_select,
  first_conv_ref_from_pin,
  first_conv_ref_from_dac,
  second_conv_ref_from_pin,
  second_conv_ref_from_supply,
  internal_ref_ready
);
  input                        sys_clk;
  input                        rst_n;
  input                        sys_ce;
  input  [`VRC_ADDR_W-1:0]     sfr_addr;
  input                        sfr_wr;
  input                        sfr_rd;
  input  [`VRC_DATA_W-1:0]     sfr_wdata;
  output [`VRC_DATA_W-1:0]     sfr_rdata;
  output                       sfr_rd_hit;
  input  [`VRC_TEMP_W-1:0]     temp_sensor_code;
  output [`VRC_TEMP_W-1:0]     temp_mux_code;
  output                       temp_mux_oe;
  output                       ref_pin_o;
  output                       ref_pin_oe;
  output                       temp_sensor_enable;
  output                       bias_generator_enable;
  output                       reference_buffer_enable;
  output                       first_converter_ref_select;
  output                       second_converter_ref_select;
  output                       first_conv_ref_from_pin;
  output                       first_conv_ref_from_dac;
  output                       second_conv_ref_from_pin;
  output                       second_conv_ref_from_supply;
  output                       internal_ref_ready;

  wire                         sys_clk;
  wire                         rst_n;
  wire                         sys_ce;
  wire   [`VRC_ADDR_W-1:0]     sfr_addr;
  wire                         sfr_wr;
  wire                         sfr_rd;
  wire   [`VRC_DATA_W-1:0]     sfr_wdata;
  wire   [`VRC_TEMP_W-1:0]     temp_sensor_code;

  wire   [`VRC_DATA_W-1:0]     sfr_rdata;
  wire                         sfr_rd_hit;
  wire   [`VRC_TEMP_W-1:0]     temp_mux_code;
  wire                         temp_mux_oe;
  wire                         ref_pin_o;
  wire                         ref_pin_oe;
  wire                         temp_sensor_enable;
  wire                         bias_generator_enable;
  wire                         reference_buffer_enable;
  wire                         first_converter_ref_select;
  wire                         second_converter_ref_select;
  wire                         first_conv_ref_from_pin;
  wire                         first_conv_ref_from_dac;
  wire                         second_conv_ref_from_pin;
  wire                         second_conv_ref_from_supply;
  wire                         internal_ref_ready;

  reg    [`VRC_DATA_W-1:0]     rdata_reg;
  reg    [`VRC_DATA_W-1:0]     rdata_next;
  reg                          rd_hit_reg;
  reg                          rd_hit_next;
  reg    [`VRC_TEMP_W-1:0]     temp_code_reg;
  reg    [`VRC_TEMP_W-1:0]     temp_code_next;
  reg                          temp_oe_reg;
  reg                          temp_oe_next;
  reg                          ready_reg;
  reg                          ready_next;

  wire   [`VRC_DATA_W-1:0]     ctrl_q;
  wire                         wr_hit;
  wire                         rd_hit;
  localparam [`VRC_DATA_W-1:0] RESET_VAL = `VRC_REF_CTRL_RESET;

  // address decode shared by the read and the write path
  function addr_match;
    input [`VRC_ADDR_W-1:0] addr;
    begin
      addr_match = (addr == `VRC_REF_CTRL_ADDR); // [R1]
    end
  endfunction

  assign wr_hit = sfr_wr && addr_match(sfr_addr);
  assign rd_hit = sfr_rd && addr_match(sfr_addr);

  vrc_ctrl_bits u_ctrl_bits
  (
    .sys_clk                   (sys_clk),
    .rst_n                     (rst_n),
    .sys_ce                    (sys_ce),
    .wr_en                     (wr_hit),
    .wr_data                   (sfr_wdata),
    .q                         (ctrl_q)
  );

  // read returns the value before any write in the same cycle
  always @*
  begin
    rdata_next  = rdata_reg;
    rd_hit_next = 1'b0;
    if (rd_hit)
    begin
      rdata_next  = ctrl_q & `VRC_REF_CTRL_MASK; // [R2]
      rd_hit_next = 1'b1;
    end
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg  <= `VRC_REF_CTRL_RESET;
      rd_hit_reg <= 1'b0;
    end
    else if (sys_ce)
    begin
      rdata_reg  <= rdata_next;
      rd_hit_reg <= rd_hit_next;
    end
  end

  assign sfr_rdata  = rdata_reg;
  assign sfr_rd_hit = rd_hit_reg;

  // sensor path into the first converter's top mux input
  always @*
  begin
    temp_oe_next   = ctrl_q[`VRC_BIT_TEMP_EN]; // [R3]
    temp_code_next = `VRC_TEMP_IDLE_CODE;
    if (ctrl_q[`VRC_BIT_TEMP_EN])
      temp_code_next = temp_sensor_code;
    // a disabled sensor floats; code is forced idle so nothing mistakes it for data
    else
      temp_code_next = `VRC_TEMP_IDLE_CODE; // [R4]
  end

  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      temp_code_reg <= `VRC_TEMP_IDLE_CODE;
      temp_oe_reg   <= 1'b0;
    end
    else if (sys_ce)
    begin
      temp_code_reg <= temp_code_next;
      temp_oe_reg   <= temp_oe_next; // [R4]
    end
  end

  assign temp_mux_code = temp_code_reg;
  assign temp_mux_oe   = temp_oe_reg;

  // enables straight from the storage flops
  assign temp_sensor_enable      = ctrl_q[`VRC_BIT_TEMP_EN]; // [R3]
  assign bias_generator_enable   = ctrl_q[`VRC_BIT_BIAS_EN]; // [R5]
  assign reference_buffer_enable = ctrl_q[`VRC_BIT_BUF_EN]; // [R6]

  // buffer drives the pin only while enabled, otherwise the pin floats
  assign ref_pin_o  = ctrl_q[`VRC_BIT_BUF_EN]; // [R6]
  assign ref_pin_oe = ctrl_q[`VRC_BIT_BUF_EN]; // [R7]

  // reference multiplexer steering, one-hot per converter
  assign first_converter_ref_select  = ctrl_q[`VRC_BIT_CONV1_SEL]; // [R8]
  assign first_conv_ref_from_pin     = ~ctrl_q[`VRC_BIT_CONV1_SEL]; // [R8]
  assign first_conv_ref_from_dac     = ctrl_q[`VRC_BIT_CONV1_SEL]; // [R8]
  assign second_converter_ref_select = ctrl_q[`VRC_BIT_CONV2_SEL]; // [R9]
  assign second_conv_ref_from_pin    = ~ctrl_q[`VRC_BIT_CONV2_SEL]; // [R9]
  assign second_conv_ref_from_supply = ctrl_q[`VRC_BIT_CONV2_SEL]; // [R9]

  // status only: the bandgap is usable as reference when software set both
  // enables; settling time of the analog part is not modelled here
  always @*
  begin
    ready_next = ready_reg;
    if (wr_hit)
      ready_next = sfr_wdata[`VRC_BIT_BIAS_EN] & sfr_wdata[`VRC_BIT_BUF_EN]; // [R10]
  end

  // own flop, loaded at the same edge as the register, so it keeps step with the enables
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ready_reg <= RESET_VAL[`VRC_BIT_BIAS_EN] & RESET_VAL[`VRC_BIT_BUF_EN];
    else if (sys_ce)
      ready_reg <= ready_next;
  end

  assign internal_ref_ready = ready_reg; // [R10]

endmodule // vrc_reference_control

// ---- design/vrc_defines.vh ----
// constants for the voltage reference control register block
`ifndef VRC_DEFINES_VH
`define VRC_DEFINES_VH

`define VRC_DATA_W            8
`define VRC_ADDR_W            8
`define VRC_TEMP_W            12

`define VRC_REF_CTRL_ADDR     8'hd1
`define VRC_REF_CTRL_RESET    8'h00
`define VRC_REF_CTRL_MASK     8'h1f

`define VRC_BIT_BUF_EN        0
`define VRC_BIT_BIAS_EN       1
`define VRC_BIT_TEMP_EN       2
`define VRC_BIT_CONV2_SEL     3
`define VRC_BIT_CONV1_SEL     4

`define VRC_TEMP_IDLE_CODE    12'h000

`endif

// ---- design/vrc_ctrl_bits.v ----
// storage cells of the reference control register, reserved bits have none
`timescale 1ns/1ps
`include "vrc_defines.vh"
module vrc_ctrl_bits
(
  sys_clk,
  rst_n,
  sys_ce,
  wr_en,
  wr_data,
  q
);
  input                        sys_clk;
  input                        rst_n;
  input                        sys_ce;
  input                        wr_en;
  input  [`VRC_DATA_W-1:0]     wr_data;
  output [`VRC_DATA_W-1:0]     q;

  wire                         sys_clk;
  wire                         rst_n;
  wire                         sys_ce;
  wire                         wr_en;
  wire   [`VRC_DATA_W-1:0]     wr_data;
  wire   [`VRC_DATA_W-1:0]     q;

  localparam [`VRC_DATA_W-1:0] STORE_MASK = `VRC_REF_CTRL_MASK;
  localparam [`VRC_DATA_W-1:0] RESET_VAL  = `VRC_REF_CTRL_RESET;

  genvar i;
  generate
    for (i = 0; i < `VRC_DATA_W; i = i + 1)
    begin : g_bit
      if (STORE_MASK[i])
      begin : g_store
        reg bit_reg;
        always @(posedge sys_clk or negedge rst_n)
        begin
          if (!rst_n)
            bit_reg <= RESET_VAL[i]; // [R1]
          else if (sys_ce && wr_en)
            bit_reg <= wr_data[i];
        end
        assign q[i] = bit_reg;
      end
      else
      begin : g_empty
        // no flop at all, so a write cannot leave a stale bit behind
        assign q[i] = 1'b0; // [R2]
      end
    end
  endgenerate

endmodule // vrc_ctrl_bits

// ---- verif/vrc_reference_control_props.sv ----
// checker for the voltage reference control register
`timescale 1ns/1ps
module vrc_reference_control_props
(
  input logic        sys_clk,
  input logic        rst_n,
  input logic        sys_ce,
  input logic [7:0]  sfr_addr,
  input logic        sfr_wr,
  input logic        sfr_rd,
  input logic [7:0]  sfr_wdata,
  input logic [7:0]  sfr_rdata,
  input logic        sfr_rd_hit,
  input logic [11:0] temp_sensor_code,
  input logic [11:0] temp_mux_code,
  input logic        temp_mux_oe,
  input logic        temp_sensor_enable,
  input logic        bias_generator_enable,
  input logic        reference_buffer_enable,
  input logic        first_converter_ref_select,
  input logic        second_converter_ref_select,
  input logic        ref_pin_oe,
  input logic        first_conv_ref_from_dac,
  input logic        second_conv_ref_from_supply,
  input logic        internal_ref_ready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire       wr_hit = sys_ce && sfr_wr && sfr_addr == 8'hd1;
  wire       rd_hit = sys_ce && sfr_rd && sfr_addr == 8'hd1;
  wire [4:0] bits   = {first_converter_ref_select, second_converter_ref_select,
                       temp_sensor_enable, bias_generator_enable, reference_buffer_enable};
  write_bits_a:
    assert property (wr_hit |=> bits == $past(sfr_wdata[4:0])) else $error("bad write");
  hold_bits_a: assert property (!wr_hit |=> $stable(bits)) else $error("bits moved");
  read_hit_a: assert property (rd_hit |=> sfr_rd_hit) else $error("no hit");
  stray_hit_a:
    assert property (sys_ce && !rd_hit |=> !sfr_rd_hit) else $error("stray hit");
  read_data_a:
    assert property (rd_hit |=> sfr_rdata == {3'b000, $past(bits)}) else $error("bad rdata");
  sensor_oe_a:
    assert property (sys_ce |=> temp_mux_oe == $past(temp_sensor_enable)) else $error("bad oe");
  sensor_code_a:
    assert property (sys_ce && temp_sensor_enable |=> temp_mux_code == $past(temp_sensor_code)) else $error("bad code");
  sensor_hiz_a: assert property (!temp_mux_oe |-> temp_mux_code == 12'h000) else $error("code leaks");
  buffer_pin_a:
    assert property (wr_hit |=> ref_pin_oe == $past(sfr_wdata[0])) else $error("bad pin oe");
  ref_steer_a:
    assert property (wr_hit |=> {first_conv_ref_from_dac, second_conv_ref_from_supply} == $past(sfr_wdata[4:3]))
      else $error("bad steer");
  ref_ready_a:
    assert property (wr_hit |=> internal_ref_ready == ($past(sfr_wdata[1]) && $past(sfr_wdata[0])))
      else $error("bad ready");
  cover property (wr_hit && sfr_wdata[4:0] == 5'h1f);
  cover property (rd_hit && sfr_wr);
  cover property ($rose(temp_mux_oe));
  cover property ($rose(internal_ref_ready));
endmodule // vrc_reference_control_props

bind vrc_reference_control vrc_reference_control_props vrc_reference_control_props_i (.*);

// ---- verif/vrc_reference_control_bench.sv ----
// self-checking bench for the voltage reference control register
`timescale 1ns/1ps
module vrc_reference_control_bench;
  logic        sys_clk, rst_n, sys_ce, sfr_wr, sfr_rd;
  logic [7:0]  sfr_addr, sfr_wdata;
  logic [11:0] temp_sensor_code;
  wire  [7:0]  sfr_rdata;
  wire  [11:0] temp_mux_code;
  wire         sfr_rd_hit, temp_mux_oe, ref_pin_o, ref_pin_oe, internal_ref_ready;
  wire         temp_sensor_enable, bias_generator_enable, reference_buffer_enable;
  wire         first_converter_ref_select, second_converter_ref_select;
  wire         first_conv_ref_from_pin, first_conv_ref_from_dac;
  wire         second_conv_ref_from_pin, second_conv_ref_from_supply;
  wire  [4:0]  bits  = {first_converter_ref_select, second_converter_ref_select,
                        temp_sensor_enable, bias_generator_enable, reference_buffer_enable};
  wire  [6:0]  steer = {first_conv_ref_from_pin, first_conv_ref_from_dac, second_conv_ref_from_pin,
                        second_conv_ref_from_supply, ref_pin_oe, ref_pin_o, internal_ref_ready};
  int          err_count = 0;
  int          n_compared = 0;
  vrc_reference_control vrc_reference_control_i (.*);
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one strobe cycle, then idle; outputs are looked at 2 ns after the taking edge
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #2;
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {w, r, a, d};
    @(posedge sys_clk);
    #2;
    {sfr_wr, sfr_rd} = 2'b00;
  endtask
  task automatic t_reset;
    check({bits, steer}, 12'h050);
    acc(0, 1, 8'hd1, 8'h00);
    check({sfr_rd_hit, sfr_rdata}, 9'h100);
    $display("reset test done");
  endtask
  task automatic t_midreset;
    acc(1, 0, 8'hd1, 8'h1f);
    acc(0, 1, 8'hd1, 8'h00);
    rst_n = 0;
    #1;
    check({sfr_rd_hit, sfr_rdata, bits, steer}, {9'h000, 5'h00, 7'h50});
    @(posedge sys_clk);
    #2;
    rst_n = 1;
    acc(0, 1, 8'hd1, 8'h00);
    check({sfr_rd_hit, sfr_rdata}, 9'h100);
    $display("mid-run reset test done");
  endtask
  task automatic t_usage;
    acc(1, 0, 8'hd1, 8'h13);
    check({bits, steer}, 12'h9b7);
    acc(1, 0, 8'hd1, 8'h0a);
    check({bits, steer}, 12'h548);
    acc(1, 0, 8'hd1, 8'h00);
    check({bits, steer}, 12'h050);
    $display("usage test done");
  endtask
  task automatic t_bits;
    logic [4:0] e;
    for (int i = 0; i < 5; i++)
    begin
      e = 5'h01 << i;
      acc(1, 0, 8'hd1, {3'b111, e});
      check({bits, steer}, {e, ~e[4], e[4], ~e[3], e[3], e[0], e[0], 1'b0});
      acc(0, 1, 8'hd1, 8'h00);
      check({sfr_rd_hit, sfr_rdata}, {4'b1000, e});
    end
    $display("bit test done");
  endtask
  task automatic t_refuse;
    acc(1, 0, 8'hd1, 8'h1f);
    acc(1, 0, 8'hd0, 8'h00);
    acc(0, 1, 8'hd2, 8'h00);
    check({sfr_rd_hit, sfr_rdata, bits}, {9'h010, 5'h1f});
    sys_ce = 0;
    acc(1, 0, 8'hd1, 8'h00);
    sys_ce = 1;
    check(bits, 5'h1f);
    // same-cycle read and write must return the value before the write
    acc(1, 1, 8'hd1, 8'h00);
    check({sfr_rd_hit, sfr_rdata, bits}, {9'h11f, 5'h00});
    $display("refusal test done");
  endtask
  task automatic t_temp;
    temp_sensor_code = 12'habc;
    acc(1, 0, 8'hd1, 8'h04);
    @(posedge sys_clk);
    #2;
    check({temp_mux_oe, temp_mux_code}, 13'h1abc);
    acc(1, 0, 8'hd1, 8'h00);
    @(posedge sys_clk);
    #2;
    check({temp_mux_oe, temp_mux_code}, 13'h0000);
    $display("sensor test done");
  endtask
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    sys_clk = 0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    {rst_n, sys_ce, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = 20'h4_0000;
    temp_sensor_code = 12'h000;
    repeat (16) @(posedge sys_clk);
    #2;
    rst_n = 1;
    t_reset;
    t_bits;
    t_refuse;
    t_temp;
    t_usage;
    t_midreset;
    conclude;
  end
  // about twelve times the cycles the tests need
  initial
  begin
    #20000;
    err_count++;
    conclude;
  end
endmodule // vrc_reference_control_bench
